// File: hdl/pwm_temp_out.sv
// Purpose: single-wire temperature output, fixed high and temperature-set low period
// Assumes: pins sampled at 40 MHz; temperature arrives as a low-period code
// Notes: daisy-chain mode is recognised but held idle with the line released
//
// What this block does
// [R1] fixed high, temperature-dependent low period waveform
// [R2] floating rate gives 99 ms typical cycle
// [R3] mode pin sampled at reset selects mode
// [R4] continuous mode repeats waveforms without requests
// [R5] rate pin latched once, later changes ignored
// [R6] host holds line low over 20 ns
// [R7] low pulses under 20 ns ignored
// [R8] one waveform per one-shot request
// [R9] first rising edge after host release
// [R10] both periods timed by same clock
// [R11] rate pin scales high and low periods
// [R12] host decodes double-high with 93.875 slope
// [R13] after one-shot return idle, line released
`timescale 1ns/100ps
module pwm_temp_out #(
  parameter int unsigned HIGH_CYC = pwm_temp_pkg::NOM_HIGH_CYC, // nominal high period
  parameter int unsigned REQ_CYC = pwm_temp_pkg::REQ_MIN_CYC // least request low time
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_mode_select_pin, // three-state level, tri_level_t code
  input wire logic [1:0] i_rate_select_pin, // three-state level, tri_level_t code
  input wire logic [pwm_temp_pkg::CNT_W-1:0] i_low_cyc, // nominal low period for current temperature
  input wire logic i_line_in, // sensed level of the shared output line
  output logic o_line_out, // level driven onto the line
  output logic o_line_oe, // high while the device drives the line
  output logic o_busy // a waveform is in progress
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] mode_s1_q, mode_s2_q; // mode pin two-stage sync
  logic [1:0] rate_s1_q, rate_s2_q; // rate pin two-stage sync
  logic line_s1_q, line_s2_q; // line sense two-stage sync

  // only the second stage is read by logic
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_s1_q <= pwm_temp_pkg::TRI_FLOAT;
      mode_s2_q <= pwm_temp_pkg::TRI_FLOAT;
      rate_s1_q <= pwm_temp_pkg::TRI_FLOAT;
      rate_s2_q <= pwm_temp_pkg::TRI_FLOAT;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      mode_s1_q <= i_mode_select_pin;
      mode_s2_q <= mode_s1_q;
      rate_s1_q <= i_rate_select_pin;
      rate_s2_q <= rate_s1_q;
      line_s1_q <= i_line_in;
      line_s2_q <= line_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // power-up strap capture
  // ---------------------------------------------------------------
  function automatic pwm_temp_pkg::op_mode_t dec_mode(input logic [1:0] lvl);
    case (lvl)
      pwm_temp_pkg::TRI_LOW: dec_mode = pwm_temp_pkg::MODE_ONESHOT;
      pwm_temp_pkg::TRI_HIGH: dec_mode = pwm_temp_pkg::MODE_CHAIN;
      default: dec_mode = pwm_temp_pkg::MODE_CONT;
    endcase
  endfunction

  function automatic pwm_temp_pkg::rate_t dec_rate(input logic [1:0] lvl);
    case (lvl)
      pwm_temp_pkg::TRI_LOW: dec_rate = pwm_temp_pkg::RATE_QUARTER;
      pwm_temp_pkg::TRI_HIGH: dec_rate = pwm_temp_pkg::RATE_DBLHI;
      default: dec_rate = pwm_temp_pkg::RATE_NOMINAL;
    endcase
  endfunction

  // straps are caught by a clocked process once the synchroniser holds the
  // real pin level, never under the asynchronous reset itself
  logic [1:0] strap_wait_q, strap_wait_d; // settle count after reset release
  logic strap_ok_q, strap_ok_d; // straps latched
  pwm_temp_pkg::op_mode_t mode_q, mode_d; // latched operating mode
  pwm_temp_pkg::rate_t rate_q, rate_d; // latched conversion rate

  always_comb begin
    strap_wait_d = strap_wait_q;
    strap_ok_d = strap_ok_q;
    mode_d = mode_q;
    rate_d = rate_q;
    if (!strap_ok_q) begin
      if (strap_wait_q == 2'(pwm_temp_pkg::STRAP_SETTLE)) begin
        strap_ok_d = 1'b1;
        mode_d = dec_mode(mode_s2_q); // [R3]
        rate_d = dec_rate(rate_s2_q); // [R5]
      end else begin
        strap_wait_d = strap_wait_q + 2'h1;
      end
    end
    // once latched, pin changes do nothing until the next reset
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_wait_q <= 2'h0;
      strap_ok_q <= 1'b0;
      mode_q <= pwm_temp_pkg::MODE_CONT;
      rate_q <= pwm_temp_pkg::RATE_NOMINAL;
    end else begin
      strap_wait_q <= strap_wait_d;
      strap_ok_q <= strap_ok_d;
      mode_q <= mode_d;
      rate_q <= rate_d;
    end
  end

  // ---------------------------------------------------------------
  // period scaling
  // ---------------------------------------------------------------
  // quarter rate shrinks both periods, double-high doubles high and quarters
  // low; nominal with the nominal low code gives the 34/65 ms, 99 ms cycle
  function automatic logic [pwm_temp_pkg::CNT_W-1:0] scale_high(input pwm_temp_pkg::rate_t r,
                                                                input logic [pwm_temp_pkg::CNT_W-1:0] v);
    case (r)
      pwm_temp_pkg::RATE_QUARTER: scale_high = v >> pwm_temp_pkg::QUARTER_SHIFT;
      pwm_temp_pkg::RATE_DBLHI: scale_high = v << pwm_temp_pkg::DOUBLE_SHIFT;
      default: scale_high = v;
    endcase
  endfunction

  function automatic logic [pwm_temp_pkg::CNT_W-1:0] scale_low(input pwm_temp_pkg::rate_t r,
                                                               input logic [pwm_temp_pkg::CNT_W-1:0] v);
    if (r == pwm_temp_pkg::RATE_NOMINAL) begin
      scale_low = v;
    end else begin
      scale_low = v >> pwm_temp_pkg::QUARTER_SHIFT;
    end
  endfunction

  // ---------------------------------------------------------------
  // request filter: host low pulse must last at least the minimum
  // ---------------------------------------------------------------
  logic [7:0] lowcnt_q, lowcnt_d; // cycles the line has been seen low
  logic armed_q, armed_d; // a long enough low pulse was seen
  logic req_pulse; // request taken on release
  // the sensed line lags the wire by the synchroniser, so our own low period
  // would still look like a host pulse for two cycles after we release
  logic [1:0] oe_seen_q, oe_seen_d; // drive enable delayed like the line sense

  always_comb begin
    lowcnt_d = lowcnt_q;
    armed_d = armed_q;
    req_pulse = 1'b0;
    oe_seen_d = {oe_seen_q[0], o_line_oe};
    if (!line_s2_q && !o_line_oe && (oe_seen_q == 2'h0)) begin // [R13]
      if (lowcnt_q != 8'hff) begin
        lowcnt_d = lowcnt_q + 8'h01;
      end
      if (32'(lowcnt_q) + 32'd1 >= REQ_CYC) begin
        armed_d = 1'b1; // [R7]
      end
    end else begin
      lowcnt_d = 8'h00;
      if (armed_q && line_s2_q) begin
        req_pulse = 1'b1; // [R9]
      end
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lowcnt_q <= 8'h00;
      armed_q <= 1'b0;
      oe_seen_q <= 2'h0;
    end else begin
      lowcnt_q <= lowcnt_d;
      armed_q <= armed_d;
      oe_seen_q <= oe_seen_d;
    end
  end

  // ---------------------------------------------------------------
  // waveform sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_HIGH = 3'h2,
    ST_LOW = 3'h4
  } wave_st_t;

  wave_st_t st_q, st_d; // sequencer state
  logic [pwm_temp_pkg::CNT_W-1:0] low_len_q, low_len_d; // low period held for this cycle
  period_if per (); // link to the shared period counter

  // one timer serves both periods, back to back, so the ratio is clock-free
  period_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .p(per.tmr)
  ); // [R10]

  always_comb begin
    st_d = st_q;
    low_len_d = low_len_q;
    per.start = 1'b0;
    per.len = scale_high(rate_q, pwm_temp_pkg::CNT_W'(HIGH_CYC));
    unique case (st_q)
      ST_IDLE: begin
        if (strap_ok_q && ((mode_q == pwm_temp_pkg::MODE_CONT) || // [R4]
            (mode_q == pwm_temp_pkg::MODE_ONESHOT && req_pulse))) begin // [R8]
          st_d = ST_HIGH;
          per.start = 1'b1; // [R11]
          low_len_d = scale_low(rate_q, i_low_cyc); // [R1]
        end
      end
      ST_HIGH: begin
        if (per.done) begin
          st_d = ST_LOW;
          per.start = 1'b1;
          per.len = low_len_q; // [R2]
        end
      end
      ST_LOW: begin
        if (per.done) begin
          if (mode_q == pwm_temp_pkg::MODE_CONT) begin
            st_d = ST_HIGH; // back to back
            per.start = 1'b1;
            low_len_d = scale_low(rate_q, i_low_cyc);
          end else begin
            st_d = ST_IDLE; // [R13]
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ST_IDLE;
      low_len_q <= '0;
    end else begin
      st_q <= st_d;
      low_len_q <= low_len_d;
    end
  end

  // ---------------------------------------------------------------
  // line drive
  // ---------------------------------------------------------------
  logic out_q, out_d; // driven level
  logic oe_q, oe_d; // drive enable

  // idle releases the line so the host can pull it low for a request
  always_comb begin
    out_d = (st_d == ST_HIGH);
    oe_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign o_line_out = out_q;
  assign o_line_oe = oe_q;
  assign o_busy = oe_q;
endmodule

// File: include/pwm_temp_pkg.sv
// Purpose: shared constants and types for the temperature-encoded pwm output
// Assumes: 40 MHz core clock, period 25 ns
// Notes: periods are given in microseconds and converted to cycles here
package pwm_temp_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NOM_HIGH_US = 34000; // nominal high period
  localparam int unsigned NOM_LOW_US = 65000; // nominal low period at 25 C
  localparam int unsigned NOM_CYCLE_MS = 99; // typical full cycle at 25 C
  localparam int unsigned REQ_MIN_NS = 20; // shortest low pulse accepted as request
  // least time rounds up, never below one cycle
  localparam int unsigned REQ_MIN_CYC_RAW = (REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REQ_MIN_CYC = (REQ_MIN_CYC_RAW < 1) ? 1 : REQ_MIN_CYC_RAW;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
  localparam int unsigned NOM_HIGH_CYC = NOM_HIGH_US * CYC_PER_US;
  localparam int unsigned NOM_LOW_CYC = NOM_LOW_US * CYC_PER_US;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned STRAP_SETTLE = 3; // last settle count before the straps are caught
  // decode constants used by the host side
  localparam int unsigned DEC_OFFSET_C = 421;
  localparam int unsigned DEC_SLOPE_NOM = 751;
  localparam real DEC_SLOPE_DBL = 93.875;

  // ---------------------------------------------------------------
  // three-state pin encoding and decoded settings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TRI_LOW = 2'h0,
    TRI_FLOAT = 2'h1,
    TRI_HIGH = 2'h2
  } tri_level_t;

  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'h1,
    MODE_CONT = 3'h2,
    MODE_CHAIN = 3'h4
  } op_mode_t;

  typedef enum logic [2:0] {
    RATE_QUARTER = 3'h1,
    RATE_NOMINAL = 3'h2,
    RATE_DBLHI = 3'h4
  } rate_t;

  // period scaling shifts: quarter = >>2, double = <<1
  localparam int unsigned QUARTER_SHIFT = 2;
  localparam int unsigned DOUBLE_SHIFT = 1;
endpackage

// File: include/period_if.sv
// Purpose: period request/complete bundle between controller and timer
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
interface period_if;
  logic start; // load and start one period
  logic [pwm_temp_pkg::CNT_W-1:0] len; // period length in cycles
  logic done; // pulse on last cycle of the period
  modport ctrl (output start, output len, input done);
  modport tmr (input start, input len, output done);
endinterface

// File: hdl/period_timer.sv
// Purpose: counts one high or low period from the shared core clock
// Assumes: len is at least one cycle
// Notes: both periods use this counter, so their ratio tracks one clock
`timescale 1ns/100ps
module period_timer (
  input wire logic i_clk,
  input wire logic i_nrst,
  period_if.tmr p
);
  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  logic [pwm_temp_pkg::CNT_W-1:0] cnt_q, cnt_d; // cycles left
  logic run_q, run_d; // a period is in progress
  logic done_q, done_d; // registered end pulse

  // next-state: start reloads, otherwise count down to one
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (p.start) begin
      cnt_d = p.len;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= pwm_temp_pkg::CNT_W'(1)) begin
        run_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - pwm_temp_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end

  assign p.done = done_q;
endmodule

// File: sim/host_timer_model.sv
// Purpose: host side of the line, pulls it low to ask for a reading
// Assumes: line has a pull-up in the bench
// Notes: measuring is left to the bench monitor
`timescale 1ns/100ps
module host_timer_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_len,
  output logic o_pull_low
);
  logic [7:0] left_q = 8'h0; // cycles of pull-low still to go
  assign o_pull_low = left_q != 8'h0;
  // ----------------------------------------
  // pull low for i_len cycles, then release
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_go && left_q == 8'h0) begin
      left_q <= i_len;
    end else if (left_q != 8'h0) begin
      left_q <= left_q - 8'h1;
    end
  end
endmodule

// File: sim/pwm_temp_out_sva.sv
// Purpose: port checks for the temperature pwm output
// Assumes: one clock, async low reset, pins stable per power-up
// Notes: run lengths are counted in helper logic
`timescale 1ns/100ps
module pwm_temp_out_sva #(
  parameter int unsigned HIGH_CYC = pwm_temp_pkg::NOM_HIGH_CYC,
  parameter int unsigned REQ_CYC = pwm_temp_pkg::REQ_MIN_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_mode_select_pin,
  input wire logic [1:0] i_rate_select_pin,
  input wire logic [pwm_temp_pkg::CNT_W-1:0] i_low_cyc,
  input wire logic i_line_in,
  input wire logic o_line_out,
  input wire logic o_line_oe,
  input wire logic o_busy
);
  logic [31:0] hi_q, lo_q, first_q, len_q; // runs, first high, low code
  wire logic drv_hi = o_line_oe && o_line_out;
  wire logic hi_end = o_line_oe && !o_line_out && hi_q != 32'h0;
  wire logic lo_end = (!o_line_oe || o_line_out) && lo_q != 32'h0;
  // low is scaled alike for quarter and double-high, so the first high tells the rate
  wire logic [31:0] exp_lo = (first_q == HIGH_CYC + 1) ? len_q + 1 : (len_q >> 2) + 1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // run counters
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_q <= 32'h0;
      lo_q <= 32'h0;
      first_q <= 32'h0;
      len_q <= 32'h0;
    end else begin
      hi_q <= drv_hi ? hi_q + 32'h1 : 32'h0;
      lo_q <= (o_line_oe && !o_line_out) ? lo_q + 32'h1 : 32'h0;
      if (hi_end && first_q == 32'h0) begin
        first_q <= hi_q;
      end
      if (drv_hi && hi_q == 32'h0) begin
        len_q <= i_low_cyc;
      end
    end
  end
  property p_busy_oe; o_busy == o_line_oe; endproperty
  a_busy_oe: assert property (p_busy_oe) else $error("busy differs from enable");
  property p_out_oe; o_line_out |-> o_line_oe; endproperty
  a_out_oe: assert property (p_out_oe) else $error("high level without enable");
  property p_start_high; $rose(o_line_oe) |-> o_line_out; endproperty
  a_start_high: assert property (p_start_high) else $error("wave not opening high");
  property p_released; $rose(o_line_oe) |-> $past(i_line_in); endproperty
  a_released: assert property (p_released) else $error("drive while line held");
  property p_end_low; $fell(o_line_oe) |-> !$past(o_line_out); endproperty
  a_end_low: assert property (p_end_low) else $error("wave ended in high");
  property p_hi_set;
    hi_end |-> hi_q == (HIGH_CYC >> 2) + 1 || hi_q == HIGH_CYC + 1 || hi_q == (HIGH_CYC << 1) + 1;
  endproperty
  a_hi_set: assert property (p_hi_set) else $error("high length off scale");
  property p_hi_fixed; hi_end && first_q != 32'h0 |-> hi_q == first_q; endproperty
  a_hi_fixed: assert property (p_hi_fixed) else $error("high length moved");
  property p_lo_len; lo_end |-> lo_q == exp_lo; endproperty
  a_lo_len: assert property (p_lo_len) else $error("low length wrong");
  property p_cont; i_mode_select_pin == 2'h1 |-> !$fell(o_line_oe); endproperty
  a_cont: assert property (p_cont) else $error("gap in continuous run");
  property p_chain; i_mode_select_pin == 2'h2 |-> !o_line_oe; endproperty
  a_chain: assert property (p_chain) else $error("drive in chain mode");
  property p_take;
    i_mode_select_pin == 2'h0 && $rose(o_line_oe) |->
      !$past(i_line_in, 5) || !$past(i_line_in, 6) || !$past(i_line_in, 7);
  endproperty
  a_take: assert property (p_take) else $error("wave without request");
endmodule
bind pwm_temp_out pwm_temp_out_sva #(.HIGH_CYC(HIGH_CYC), .REQ_CYC(REQ_CYC)) u_sva (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_mode_select_pin(i_mode_select_pin),
  .i_rate_select_pin(i_rate_select_pin), .i_low_cyc(i_low_cyc), .i_line_in(i_line_in),
  .o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_busy(o_busy));

// File: sim/tb_top.sv
// Purpose: self-checking bench for the temperature pwm output
// Assumes: short high period, request needs 3 synced low cycles
// Notes: monitor pops the oldest noted wave on each finished wave
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned HC = 40; // shortened high period keeps the run brief
  logic i_clk = 1'b0, i_nrst = 1'b0, go = 1'b0;
  logic [1:0] mode = 2'h0, rate = 2'h1;
  logic [31:0] low = 32'h10, hc = 32'h0, lc = 32'h0;
  logic [7:0] glen = 8'h0;
  logic pull_low, out, oe, busy;
  wire logic line = oe ? out : !pull_low; // pull-up when nobody drives
  logic [31:0] q_th[$], q_tl[$];
  int err_count = 0, checks_done = 0;
  always #12.5 i_clk = ~i_clk;
  pwm_temp_out #(.HIGH_CYC(HC), .REQ_CYC(3)) dut (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_mode_select_pin(mode), .i_rate_select_pin(rate), .i_low_cyc(low), .i_line_in(line),
    .o_line_out(out), .o_line_oe(oe), .o_busy(busy));
  host_timer_model host (.i_clk(i_clk), .i_go(go), .i_len(glen), .o_pull_low(pull_low));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // one compare per kind of result, all sharing the counting above
  task automatic check_len(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_val(nm, e, g);
  endtask
  task automatic check_count(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_val(nm, e, g);
  endtask
  task automatic check_busy(input logic g);
    check_val("busy", 32'h0, {31'h0, g});
  endtask
  task automatic check_decode(input logic [31:0] e, input logic [31:0] g);
    check_val("decode", e, g);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic power_up(input logic [1:0] m, input logic [1:0] r);
    @(negedge i_clk);
    i_nrst = 1'b0;
    mode = m;
    rate = r;
    // multiples of four keep the quarter low exact, so both decode slopes agree
    low = 32'h8 + (($urandom % 10) << 2);
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
  task automatic expect_wave(input logic [1:0] r);
    q_th.push_back(r == 2'h0 ? (HC >> 2) + 1 : r == 2'h2 ? (HC << 1) + 1 : HC + 1);
    q_tl.push_back(r == 2'h0 || r == 2'h2 ? (low >> 2) + 1 : low + 1);
  endtask
  task automatic request(input logic [7:0] n);
    glen = n;
    go = 1'b1;
    @(negedge i_clk);
    go = 1'b0;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 3000 && q_th.size() > 0; i++) @(negedge i_clk);
    check_count("pending", 32'h0, 32'(q_th.size()));
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge i_clk);
      check_busy(busy);
    end
  endtask
  task automatic check_wave;
    logic [31:0] eh, nom, dbl;
    if (q_th.size() == 0) check_count("extra wave", 32'h0, 32'h1);
    else begin
      eh = q_th.pop_front();
      check_len("high", eh, hc);
      check_len("low", q_tl.pop_front(), lc);
      // a host on the double-high rate decodes with its own slope and must land
      // on the reading that the nominal equation gives for the same low code
      if (eh == (HC << 1) + 1) begin
        nom = 32'(8 * pwm_temp_pkg::DEC_SLOPE_NOM * HC) * (lc - 32'h1);
        dbl = 32'($rtoi(pwm_temp_pkg::DEC_SLOPE_DBL * 8.0)) * (hc - 32'h1) * low;
        check_decode(nom, dbl);
      end
    end
    hc = 32'h0;
    lc = 32'h0;
  endtask
  // ----------------------------------------
  // monitor: counts driven cycles just after each rising edge
  // ----------------------------------------
  always @(posedge i_clk) begin
    #1;
    if (i_nrst !== 1'b1) begin
      hc = 32'h0;
      lc = 32'h0;
    end else if (oe === 1'b1 && out === 1'b1) begin
      if (lc != 32'h0) check_wave();
      hc = hc + 32'h1;
    end else if (oe === 1'b1) lc = lc + 32'h1;
    else if (hc != 32'h0 || lc != 32'h0) check_wave();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h63f529b8));
    for (int r = 0; r < 4; r++) begin
      power_up(2'h0, 2'(r));
      expect_wave(2'(r));
      request(8'h6);
      wait_done();
      idle(30);
      rate = 2'(r) ^ 2'h2; // pin moves after power-up
      expect_wave(2'(r));
      request(8'h6);
      wait_done();
      request(8'h1);
      idle(40);
    end
    for (int r = 1; r < 3; r++) begin
      power_up(2'h1, 2'(r));
      repeat (3) expect_wave(2'(r));
      wait_done();
    end
    power_up(2'h2, 2'h1);
    request(8'h6);
    idle(200);
    results();
  end
  initial begin
    #(25 * 60000);
    err_count++;
    results();
  end
endmodule
